// *** core/gpom_pkg.sv ***
package gpom_pkg;

  // Register map: offset 0x14 is a multiple of four, so it is the byte address
  localparam logic [7:0]  CTRL_ADDR     = 8'h14;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  ID_ADDR       = 8'h18;
  localparam logic [7:0]  STATUS_ADDR   = 8'h1C;
  localparam logic [7:0]  ENABLE_ADDR   = 8'h20;
  localparam logic [7:0]  ROUTE_ADDR    = 8'h24;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VALUE      = 32'h0000_6A01;

  // Field layout of general_pin_output_control
  localparam int          SEL_MSB       = 7;
  localparam int          SEL_LSB       = 5;
  localparam int          SRC_MSB       = 4;
  localparam int          SRC_LSB       = 2;
  localparam int          VAL_BIT       = 1;
  localparam int          EN_BIT        = 0;

  // Source group codes
  localparam logic [2:0]  SRC_RX0       = 3'h0;
  localparam logic [2:0]  SRC_RX3       = 3'h3;
  localparam logic [2:0]  SRC_STATUS    = 3'h4;
  localparam logic [2:0]  SRC_RSVD      = 3'h5;
  localparam logic [2:0]  SRC_TX0       = 3'h6;
  localparam logic [2:0]  SRC_TX1       = 3'h7;

  // Signal codes
  localparam logic [2:0]  SIG_0         = 3'h0;
  localparam logic [2:0]  SIG_1         = 3'h1;
  localparam logic [2:0]  SIG_2         = 3'h2;
  localparam logic [2:0]  SIG_3         = 3'h3;
  localparam logic [2:0]  SIG_4         = 3'h4;
  localparam logic [2:0]  SIG_5         = 3'h5;
  localparam logic [2:0]  SIG_6         = 3'h6;
  localparam logic [2:0]  SIG_7         = 3'h7;

  // APB access phase states
  typedef enum logic [1:0] {
    GPOM_IDLE   = 2'b01,
    GPOM_ACCESS = 2'b10
  } gpom_apb_e;

endpackage

// *** core/gpom_rx_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

// Selects one receive port's signal by source and signal codes
module gpom_rx_pick #(
  parameter int NRX = 4
) (
  // Selection
  input  wire logic [1:0]       port_sel,
  input  wire logic [2:0]       sig_sel,
  // Receive port signals
  input  wire logic [4*NRX-1:0] rx_remote_gpio,
  input  wire logic [NRX-1:0]   rx_lock,
  input  wire logic [NRX-1:0]   rx_pass,
  input  wire logic [NRX-1:0]   rx_frame_valid,
  input  wire logic [NRX-1:0]   rx_line_valid,
  // Result
  output logic                  picked
);

  wire logic [7:0] port_vec [NRX];

  genvar g;
  generate
    for (g = 0; g < NRX; g++)
    begin : g_port
      assign port_vec[g] = {rx_line_valid[g], rx_frame_valid[g], rx_pass[g],
                            rx_lock[g], rx_remote_gpio[4*g +: 4]};
    end
  endgenerate

  // Codes 0..3 remote inputs, 4 lock, 5 pass, 6 frame, 7 line
  assign picked = port_vec[port_sel][sig_sel];

endmodule

`default_nettype wire

// *** core/gpom_tx_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

// Selects one transmit port's signal
module gpom_tx_pick #(
  parameter int NRX = 4
) (
  // Selection
  input  wire logic             tx_sel,
  input  wire logic [2:0]       sig_sel,
  // Transmit port status
  input  wire logic [2*NRX-1:0] tx_rx_map,
  input  wire logic [NRX-1:0]   rx_pass,
  input  wire logic [1:0]       tx_frame_active,
  input  wire logic [1:0]       tx_line_active,
  input  wire logic [1:0]       tx_synced,
  input  wire logic [1:0]       tx_irq,
  // Result
  output logic                  picked
);

  wire logic [NRX-1:0] feed      = tx_rx_map[NRX*tx_sel +: NRX];
  wire logic           pass_and  = &(rx_pass | ~feed) && (|feed);
  wire logic           pass_or   = |(rx_pass & feed);

  // Codes 0..5 defined, 6 and 7 read low
  assign picked = (sig_sel == gpom_pkg::SIG_0) ? pass_and :
                  (sig_sel == gpom_pkg::SIG_1) ? pass_or :
                  (sig_sel == gpom_pkg::SIG_2) ? tx_frame_active[tx_sel] :
                  (sig_sel == gpom_pkg::SIG_3) ? tx_line_active[tx_sel] :
                  (sig_sel == gpom_pkg::SIG_4) ? tx_synced[tx_sel] :
                  (sig_sel == gpom_pkg::SIG_5) ? tx_irq[tx_sel] :
                  1'b0;

endmodule

`default_nettype wire

// *** core/gpom_pin_mux.sv ***
`timescale 1ns/1ps
`default_nettype none

module gpom_pin_mux #(
  parameter int NRX = 4
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // Receive port signals
  input  wire logic [4*NRX-1:0] rx_remote_gpio,
  input  wire logic [NRX-1:0]   rx_lock,
  input  wire logic [NRX-1:0]   rx_pass,
  input  wire logic [NRX-1:0]   rx_frame_valid,
  input  wire logic [NRX-1:0]   rx_line_valid,
  // Device status
  input  wire logic             frame_sync_pulse,
  // Transmit port signals
  input  wire logic [1:0]       tx_frame_active,
  input  wire logic [1:0]       tx_line_active,
  input  wire logic [1:0]       tx_synced,
  input  wire logic [1:0]       tx_irq,
  // General pin four
  input  wire logic             general_pin_four_in,
  output logic                  general_pin_four_out,
  output logic                  general_pin_four_oe
);

  // Registers
  logic [7:0]       ctrl_q;
  logic [NRX-1:0]   rx_enable_q;
  logic [2*NRX-1:0] tx_route_q;
  logic             pin_out_q;
  logic             pin_oe_q;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  gpom_pkg::gpom_apb_e apb_q;

  // Field views
  wire logic [2:0] pin_signal_select       = ctrl_q[gpom_pkg::SEL_MSB:gpom_pkg::SEL_LSB];
  wire logic [2:0] pin_source_group_select = ctrl_q[gpom_pkg::SRC_MSB:gpom_pkg::SRC_LSB];
  wire logic       pin_local_level         = ctrl_q[gpom_pkg::VAL_BIT];
  wire logic       pin_drive_enable        = ctrl_q[gpom_pkg::EN_BIT];

  // APB decode
  wire logic setup_phase = psel && !penable;
  wire logic access_done = psel && penable && pready_q;
  wire logic hit_ctrl    = (paddr == gpom_pkg::CTRL_ADDR);
  wire logic hit_id      = (paddr == gpom_pkg::ID_ADDR);
  wire logic hit_status  = (paddr == gpom_pkg::STATUS_ADDR);
  wire logic hit_enable  = (paddr == gpom_pkg::ENABLE_ADDR);
  wire logic hit_route   = (paddr == gpom_pkg::ROUTE_ADDR);
  wire logic hit_any     = hit_ctrl || hit_id || hit_status || hit_enable || hit_route;
  wire logic read_only   = hit_id || hit_status;
  wire logic bad_access  = !hit_any || (pwrite && read_only);
  wire logic wr_ok       = access_done && pwrite && !bad_access && pstrb[0];
  wire logic wr_ctrl     = wr_ok && hit_ctrl;
  wire logic wr_enable   = wr_ok && hit_enable;
  wire logic wr_route    = wr_ok && hit_route;

  // Device status group
  wire logic lock_or  = |(rx_lock & rx_enable_q);
  wire logic lock_and = (|rx_enable_q) && &(rx_lock | ~rx_enable_q);
  wire logic pass_and = (|rx_enable_q) && &(rx_pass | ~rx_enable_q);

  wire logic status_pick =
    (pin_signal_select == gpom_pkg::SIG_0) ? pin_local_level :
    (pin_signal_select == gpom_pkg::SIG_1) ? lock_or :
    (pin_signal_select == gpom_pkg::SIG_2) ? lock_and :
    (pin_signal_select == gpom_pkg::SIG_3) ? pass_and :
    (pin_signal_select == gpom_pkg::SIG_4) ? frame_sync_pulse :
    1'b0;

  wire logic rx_pick;
  wire logic tx_pick;

  gpom_rx_pick #(
    .NRX            (NRX)
  ) u_rx (
    .port_sel       (pin_source_group_select[1:0]),
    .sig_sel        (pin_signal_select),
    .rx_remote_gpio (rx_remote_gpio),
    .rx_lock        (rx_lock),
    .rx_pass        (rx_pass),
    .rx_frame_valid (rx_frame_valid),
    .rx_line_valid  (rx_line_valid),
    .picked         (rx_pick)
  );

  gpom_tx_pick #(
    .NRX             (NRX)
  ) u_tx (
    .tx_sel          (pin_source_group_select[0]),
    .sig_sel         (pin_signal_select),
    .tx_rx_map       (tx_route_q),
    .rx_pass         (rx_pass),
    .tx_frame_active (tx_frame_active),
    .tx_line_active  (tx_line_active),
    .tx_synced       (tx_synced),
    .tx_irq          (tx_irq),
    .picked          (tx_pick)
  );

  // Source group selection
  wire logic src_is_rx = !pin_source_group_select[2];
  wire logic src_is_st = (pin_source_group_select == gpom_pkg::SRC_STATUS);
  wire logic src_is_tx = (pin_source_group_select[2:1] == gpom_pkg::SRC_TX0[2:1]);
  wire logic pin_d     = src_is_rx ? rx_pick :
                         src_is_st ? status_pick :
                         src_is_tx ? tx_pick : 1'b0;

  // Read data selection
  wire logic [31:0] rd_d =
    hit_ctrl   ? {24'h000000, ctrl_q} :
    hit_id     ? gpom_pkg::ID_VALUE :
    hit_status ? {30'h0, general_pin_four_in, pin_oe_q} :
    hit_enable ? {{(32-NRX){1'b0}}, rx_enable_q} :
    hit_route  ? {{(32-2*NRX){1'b0}}, tx_route_q} :
    32'h00000000;

  // APB handshake: no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_q     <= gpom_pkg::GPOM_IDLE;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      case (apb_q)
        gpom_pkg::GPOM_IDLE:
        begin
          pready_q  <= setup_phase;
          pslverr_q <= setup_phase && bad_access;
          prdata_q  <= (setup_phase && !pwrite) ? rd_d : 32'h00000000;
          if (setup_phase)
            apb_q <= gpom_pkg::GPOM_ACCESS;
        end
        gpom_pkg::GPOM_ACCESS:
        begin
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
          prdata_q  <= 32'h00000000;
          apb_q     <= gpom_pkg::GPOM_IDLE;
        end
        default:
        begin
          apb_q <= gpom_pkg::GPOM_IDLE;
        end
      endcase
    end
  end

  // Register writes, taken at the end of the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q      <= gpom_pkg::CTRL_RESET;
      rx_enable_q <= {NRX{1'b1}};
      tx_route_q  <= {2*NRX{1'b1}};
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[7:0];
      if (wr_enable)
        rx_enable_q <= pwdata[NRX-1:0];
      if (wr_route)
        tx_route_q <= pwdata[2*NRX-1:0];
    end
  end

  // Pin drive registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end
    else
    begin
      pin_out_q <= pin_drive_enable ? pin_d : 1'b0;
      pin_oe_q  <= pin_drive_enable;
    end
  end

  assign pready               = pready_q;
  assign prdata               = prdata_q;
  assign pslverr              = pslverr_q;
  assign general_pin_four_out = pin_out_q;
  assign general_pin_four_oe  = pin_oe_q;

  // Checks
  sequence ctrl_write_s;
    wr_ctrl && pwdata[gpom_pkg::EN_BIT];
  endsequence

  oe_follows_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_write_s |=> ##1 general_pin_four_oe)
    else $error("pin enable did not reach the pin");

  undriven_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(pin_drive_enable) |-> !general_pin_four_oe && !general_pin_four_out)
    else $error("pin driven while disabled");

  local_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_st && pin_signal_select == gpom_pkg::SIG_0
    |=> general_pin_four_out == $past(pin_local_level))
    else $error("local level not on pin");

  rx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_rx && !pin_signal_select[2]
    |=> general_pin_four_out ==
        $past(rx_remote_gpio[{pin_source_group_select[1:0], pin_signal_select[1:0]}]))
    else $error("remote input routing wrong");

  rx_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_rx && pin_signal_select == gpom_pkg::SIG_4
    |=> general_pin_four_out == $past(rx_lock[pin_source_group_select[1:0]]))
    else $error("lock routing wrong");

  lock_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_st && pin_signal_select == gpom_pkg::SIG_1
    |=> general_pin_four_out == $past(|(rx_lock & rx_enable_q)))
    else $error("lock OR wrong");

  sync_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_st && pin_signal_select == gpom_pkg::SIG_4
    |=> general_pin_four_out == $past(frame_sync_pulse))
    else $error("frame sync routing wrong");

  tx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_tx && pin_signal_select == gpom_pkg::SIG_5
    |=> general_pin_four_out == $past(tx_irq[pin_source_group_select[0]]))
    else $error("interrupt routing wrong");

  reserved_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_source_group_select == gpom_pkg::SRC_RSVD |=> !general_pin_four_out)
    else $error("reserved source drives high");

  ctrl_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl_q == $past(pwdata[7:0]))
    else $error("control write lost");

  // Receive ports feeding the selected transmit port
  wire logic [NRX-1:0] tx_feed = tx_route_q[NRX*pin_source_group_select[0] +: NRX];

  rx_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_rx && pin_signal_select == gpom_pkg::SIG_5
    |=> general_pin_four_out == $past(rx_pass[pin_source_group_select[1:0]]))
    else $error("pass routing wrong");

  rx_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_rx && pin_signal_select == gpom_pkg::SIG_6
    |=> general_pin_four_out == $past(rx_frame_valid[pin_source_group_select[1:0]]))
    else $error("frame valid routing wrong");

  rx_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_rx && pin_signal_select == gpom_pkg::SIG_7
    |=> general_pin_four_out == $past(rx_line_valid[pin_source_group_select[1:0]]))
    else $error("line valid routing wrong");

  lock_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_st && pin_signal_select == gpom_pkg::SIG_2
    |=> general_pin_four_out == $past((|rx_enable_q) && &(rx_lock | ~rx_enable_q)))
    else $error("lock AND wrong");

  pass_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_st && pin_signal_select == gpom_pkg::SIG_3
    |=> general_pin_four_out == $past((|rx_enable_q) && &(rx_pass | ~rx_enable_q)))
    else $error("pass AND wrong");

  status_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_is_st && pin_signal_select > gpom_pkg::SIG_4 |=> !general_pin_four_out)
    else $error("reserved status code drives high");

  tx_pass_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_tx && pin_signal_select == gpom_pkg::SIG_0
    |=> general_pin_four_out == $past((|tx_feed) && &(rx_pass | ~tx_feed)))
    else $error("transmit pass AND wrong");

  tx_pass_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_tx && pin_signal_select == gpom_pkg::SIG_1
    |=> general_pin_four_out == $past(|(rx_pass & tx_feed)))
    else $error("transmit pass OR wrong");

  tx_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_tx && pin_signal_select == gpom_pkg::SIG_2
    |=> general_pin_four_out == $past(tx_frame_active[pin_source_group_select[0]]))
    else $error("transmit frame routing wrong");

  tx_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_tx && pin_signal_select == gpom_pkg::SIG_3
    |=> general_pin_four_out == $past(tx_line_active[pin_source_group_select[0]]))
    else $error("transmit line routing wrong");

  tx_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drive_enable && src_is_tx && pin_signal_select == gpom_pkg::SIG_4
    |=> general_pin_four_out == $past(tx_synced[pin_source_group_select[0]]))
    else $error("synchronized routing wrong");

  tx_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_is_tx && pin_signal_select == gpom_pkg::SIG_7 |=> !general_pin_four_out)
    else $error("reserved transmit code drives high");

  oe_tracks_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    general_pin_four_oe == $past(pin_drive_enable))
    else $error("pin enable does not track its bit");

endmodule

`default_nettype wire

// *** sim/gpom_board.sv ***
`timescale 1ns/1ps
`default_nettype none

// Board load on general pin four, held by a pull-up
module gpom_board (
  // Pin driver from the device
  input  wire logic drive_level,
  input  wire logic drive_en,
  // Level seen on the board
  output logic      pin_level
);
  // Released pin floats to the pull-up level
  assign pin_level = drive_en ? drive_level : 1'b1;
endmodule

`default_nettype wire

// *** sim/tb_gpio_output_source_mux.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_output_source_mux;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fsync, pin_out, pin_oe, pin_lvl, err;
  logic [7:0]  paddr, route;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, lock, pass, fv, lv, en_mask;
  logic [15:0] rgpio;
  logic [1:0]  tfa, tla, tsy, tirq;
  logic [8:0]  rows [64];
  int          fails, checked, i;

  gpom_pin_mux #(.NRX(4)) gpom_pin_mux_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_remote_gpio(rgpio), .rx_lock(lock), .rx_pass(pass),
    .rx_frame_valid(fv), .rx_line_valid(lv), .frame_sync_pulse(fsync),
    .tx_frame_active(tfa), .tx_line_active(tla), .tx_synced(tsy), .tx_irq(tirq),
    .general_pin_four_in(pin_lvl), .general_pin_four_out(pin_out),
    .general_pin_four_oe(pin_oe)
  );

  gpom_board gpom_board_i (
    .drive_level(pin_out), .drive_en(pin_oe), .pin_level(pin_lvl)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Expected pin level from the control byte and the live sources
  function automatic logic exp_fn(input logic [7:0] c);
    logic [2:0] s;
    logic [2:0] g;
    logic [3:0] m;
    s = c[4:2];
    g = c[7:5];
    m = s[0] ? route[7:4] : route[3:0];
    if (!c[0])
      return 1'b0;
    if (!s[2])
    begin
      case (g)
        3'h4: return lock[s[1:0]];
        3'h5: return pass[s[1:0]];
        3'h6: return fv[s[1:0]];
        3'h7: return lv[s[1:0]];
        default: return rgpio[{s[1:0], g[1:0]}];
      endcase
    end
    if (s == 3'h4)
    begin
      case (g)
        3'h0: return c[1];
        3'h1: return |(lock & en_mask);
        3'h2: return (en_mask != 4'h0) && (&(lock | ~en_mask));
        3'h3: return (en_mask != 4'h0) && (&(pass | ~en_mask));
        3'h4: return fsync;
        default: return 1'b0;
      endcase
    end
    if (s == 3'h5)
      return 1'b0;
    case (g)
      3'h0: return (m != 4'h0) && (&(pass | ~m));
      3'h1: return |(pass & m);
      3'h2: return tfa[s[0]];
      3'h3: return tla[s[0]];
      3'h4: return tsy[s[0]];
      3'h5: return tirq[s[0]];
      default: return 1'b0;
    endcase
  endfunction

  task automatic stop_test;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setpin(input logic [7:0] c);
    apb(1'b1, gpom_pkg::CTRL_ADDR, {24'h0, c}, 4'hF);
    repeat (2) @(posedge pclk);
    chk({30'h0, pin_oe, pin_out}, {30'h0, c[0], exp_fn(c)}, "pin");
  endtask

  initial
  begin
    #200000;
    fails++;
    $display("CHECK FAILED at %0t: timeout", $time);
    stop_test();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    rgpio = 16'hA5C3; lock = 4'hB; pass = 4'h7; fv = 4'h5; lv = 4'hA;
    fsync = 1'b1; tfa = 2'h2; tla = 2'h1; tsy = 2'h2; tirq = 2'h1;
    en_mask = 4'hF; route = 8'hFF; fails = 0; checked = 0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, gpom_pkg::CTRL_ADDR, 32'h0, 4'hF);
    chk(rd, {24'h0, gpom_pkg::CTRL_RESET}, "ctrl reset");
    chk({31'h0, pin_oe}, 32'h0, "oe reset");
    $display("done: reset");
    for (i = 0; i < 64; i++)
      rows[i] = {exp_fn({i[5:0], 2'b11}), i[5:0], 2'b11};
    for (i = 0; i < 64; i++)
    begin
      setpin(rows[i][7:0]);
      chk({31'h0, pin_out}, {31'h0, rows[i][8]}, "row");
    end
    $display("done: table");
    setpin(8'h11);
    setpin(8'h13);
    setpin(8'h12);
    apb(1'b0, gpom_pkg::STATUS_ADDR, 32'h0, 4'hF);
    chk({30'h0, rd[1:0]}, 32'h2, "status");
    apb(1'b0, gpom_pkg::CTRL_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h12, "ctrl readback");
    $display("done: level and enable");
    apb(1'b1, gpom_pkg::ENABLE_ADDR, 32'h3, 4'hF);
    en_mask = 4'h3;
    setpin(8'h51);
    setpin(8'h71);
    apb(1'b1, gpom_pkg::ROUTE_ADDR, 32'h37, 4'hF);
    route = 8'h37;
    setpin(8'h19);
    setpin(8'h3D);
    $display("done: enable mask and routing");
    apb(1'b0, 8'h40, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1, "unmapped");
    apb(1'b1, gpom_pkg::ID_ADDR, 32'hFF, 4'hF);
    chk({31'h0, err}, 32'h1, "ro write");
    apb(1'b1, gpom_pkg::CTRL_ADDR, 32'hFF, 4'h0);
    apb(1'b0, gpom_pkg::CTRL_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h3D, "strobe off");
    $display("done: refusals");
    setpin(8'h91);
    @(posedge pclk);
    fsync <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, pin_out}, 32'h0, "sync low");
    $display("done: live source");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({30'h0, pin_oe, pin_out}, 32'h0, "mid reset pin");
    apb(1'b0, gpom_pkg::CTRL_ADDR, 32'h0, 4'hF);
    chk(rd, {24'h0, gpom_pkg::CTRL_RESET}, "mid reset ctrl");
    apb(1'b0, gpom_pkg::ENABLE_ADDR, 32'h0, 4'hF);
    chk(rd, 32'hF, "mid reset enable");
    $display("done: mid-run reset");
    stop_test();
  end
endmodule

`default_nettype wire
